// ### core/e1_framer_pkg.sv
// shared constants and types for the e1 multiframe framer
package e1_framer_pkg;
    localparam int          LINE_RATE_KBPS  = 2048;
    localparam int          BITS_PER_SLOT   = 8;
    localparam int          SLOTS_PER_FRAME = 32;
    localparam int          FRAMES_PER_MF   = 16;
    localparam logic [4:0]  TS_FRAMING      = 5'h00;
    localparam logic [4:0]  TS_SIGNALLING   = 5'h10;
    localparam logic [7:0]  POS_LAST        = 8'hff;
    localparam logic [3:0]  FRAME_E_SMF1    = 4'hd;
    localparam logic [3:0]  FRAME_E_SMF2    = 4'hf;
    localparam logic [3:0]  FRAME_MF_LAST   = 4'hb;
    localparam logic [6:0]  ALIGN_WORD      = 7'h1b;
    localparam logic [5:0]  MF_PATTERN      = 6'h0b;
    localparam logic [3:0]  CRC_POLY        = 4'h3;
    localparam logic [2:0]  BIT_LAST        = 3'h7;
    localparam logic [2:0]  BIT_NFAS_ONE    = 3'h1;
    localparam logic [2:0]  BIT_ALARM       = 3'h2;
    localparam logic [2:0]  BIT_SIG_SPLIT   = 3'h4;

    typedef logic [30:1][3:0] sig_table_t;

    typedef struct packed {
        logic       rai;
        logic [4:0] spare;
        logic [3:0] mf_spare;
    } tx_ctrl_t;

    typedef struct packed {
        logic frame_aligned;
        logic mf_aligned;
        logic far_alarm;
        logic far_crc_err;
        logic crc_err;
    } rx_status_t;

    typedef enum logic [3:0] {
        RX_HUNT     = 4'h1,
        RX_CHK_NFAS = 4'h2,
        RX_CHK_FAS  = 4'h4,
        RX_SYNC     = 4'h8
    } rx_state_t;
endpackage

// ### core/e1_crc4.sv
// serial crc-4 (x^4+x+1) over one sub-multiframe
`timescale 1ns/1ps
module e1_crc4
    import e1_framer_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic       din,
    output logic [3:0]      crc_q
);
    logic [3:0] base;
    logic [3:0] crc_d;
    logic       fb;

    always_comb begin
        base  = start ? 4'h0 : crc_q;
        fb    = din ^ base[3];
        crc_d = {base[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            crc_q <= 4'h0;
        end else begin
            crc_q <= crc_d;
        end
    end
endmodule // e1_crc4

// ### core/e1_multiframe_framer.sv
// e1 framer and deframer with crc-4 multiframe and signalling slot
`timescale 1ns/1ps
module e1_multiframe_framer
    import e1_framer_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [7:0]  tx_data,
    input  wire sig_table_t  tx_sig,
    input  wire tx_ctrl_t    tx_ctrl,
    output logic             tx_line_q,
    output logic [7:0]       tx_pos_q,
    output logic [3:0]       tx_frame_q,
    input  wire logic        rx_line,
    output logic [7:0]       rx_byte_q,
    output logic             rx_byte_valid_q,
    output logic [4:0]       rx_byte_ts_q,
    output logic [3:0]       rx_byte_frame_q,
    output sig_table_t       rx_sig_q,
    output rx_status_t       rx_status_q
);
    // ---------------- transmit
    logic [7:0] tx_pos_d;
    logic [3:0] tx_frame_d;
    logic       tx_line_d;
    logic [7:0] tx_hold_q;
    logic [7:0] tx_hold_d;
    logic [3:0] tx_cprev_q;
    logic [3:0] tx_cprev_d;
    logic [3:0] tx_crc;
    logic       tx_smf_start;
    logic [1:0] err_q;
    logic [1:0] err_d;
    logic [2:0] tbit;
    logic [4:0] tts;

    assign tbit         = tx_pos_q[2:0];
    assign tts          = tx_pos_q[7:3];
    assign tx_smf_start = (tx_pos_q == 8'h00) && (tx_frame_q[2:0] == 3'h0);

    always_comb begin
        tx_pos_d   = tx_pos_q + 8'h01;
        tx_frame_d = (tx_pos_q == POS_LAST) ? tx_frame_q + 4'h1 : tx_frame_q;
        tx_hold_d  = (tbit == 3'h0) ? tx_data : tx_hold_q;
        tx_cprev_d = tx_smf_start ? tx_crc : tx_cprev_q;
        if (tts == TS_FRAMING) begin
            if (!tx_frame_q[0]) begin
                if (tbit == 3'h0) begin
                    // every even frame carries a bit of the crc that finished at frame 0 or 8
                    tx_line_d = tx_cprev_d[2'(3 - tx_frame_q[2:1])];
                end else begin
                    tx_line_d = ALIGN_WORD[3'(7 - tbit)];
                end
            end else begin
                case (tbit)
                    3'h0: begin
                        if (tx_frame_q == FRAME_E_SMF1) begin
                            tx_line_d = ~err_q[0];
                        end else if (tx_frame_q == FRAME_E_SMF2) begin
                            tx_line_d = ~err_q[1];
                        end else begin
                            tx_line_d = MF_PATTERN[3'(5 - tx_frame_q[3:1])];
                        end
                    end
                    BIT_NFAS_ONE: tx_line_d = 1'b1;
                    BIT_ALARM:    tx_line_d = tx_ctrl.rai;
                    default:      tx_line_d = tx_ctrl.spare[3'(7 - tbit)];
                endcase
            end
        end else if (tts == TS_SIGNALLING) begin
            if (tx_frame_q == 4'h0) begin
                tx_line_d = (tbit < BIT_SIG_SPLIT) ? 1'b0
                          : tx_ctrl.mf_spare[2'(7 - tbit)];
            end else if (tbit < BIT_SIG_SPLIT) begin
                tx_line_d = tx_sig[tx_frame_q][2'(3 - tbit)];
            end else begin
                tx_line_d = tx_sig[5'(tx_frame_q) + 5'd15][2'(7 - tbit)];
            end
        end else begin
            tx_line_d = (tbit == 3'h0) ? tx_data[7] : tx_hold_q[3'(7 - tbit)];
        end
    end

    // crc computed with the crc bit positions forced to zero
    e1_crc4 u_tx_crc (
        .mclk   (mclk),
        .resetn (resetn),
        .start  (tx_smf_start),
        .din    ((tts == TS_FRAMING && tbit == 3'h0 && !tx_frame_q[0]) ? 1'b0 : tx_line_d),
        .crc_q  (tx_crc)
    );

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tx_pos_q   <= 8'h00;
            tx_frame_q <= 4'h0;
            tx_line_q  <= 1'b1;
            tx_hold_q  <= 8'hff;
            tx_cprev_q <= 4'h0;
        end else begin
            tx_pos_q   <= tx_pos_d;
            tx_frame_q <= tx_frame_d;
            tx_line_q  <= tx_line_d;
            tx_hold_q  <= tx_hold_d;
            tx_cprev_q <= tx_cprev_d;
        end
    end

    // ---------------- receive
    rx_state_t  st_q;
    rx_state_t  st_d;
    logic [7:0] rx_pos_q;
    logic [7:0] rx_pos_d;
    logic [3:0] rx_frame_q;
    logic [3:0] rx_frame_d;
    logic [6:0] sr_q;
    logic [6:0] sr_d;
    logic [5:0] mf_sr_q;
    logic [5:0] mf_sr_d;
    logic       mf_lock_q;
    logic       mf_lock_d;
    logic [3:0] c_rx_q;
    logic [3:0] c_rx_d;
    logic [3:0] rx_cprev_q;
    logic [3:0] rx_cprev_d;
    logic       cvalid_q;
    logic       cvalid_d;
    logic [3:0] rx_crc;
    logic       rx_smf_start;
    logic       fas_hit;
    logic [5:0] mf_word;
    logic [7:0] rbyte;
    logic [7:0] rx_byte_d;
    logic       rx_byte_valid_d;
    sig_table_t rx_sig_d;
    rx_status_t rx_status_d;

    assign fas_hit      = ({sr_q[5:0], rx_line} == ALIGN_WORD);
    assign mf_word      = {mf_sr_q[4:0], rx_line};
    assign rbyte        = {sr_q, rx_line};
    assign rx_smf_start = (rx_pos_q == 8'h00) && (rx_frame_q[2:0] == 3'h0);

    always_comb begin
        st_d            = st_q;
        rx_pos_d        = rx_pos_q + 8'h01;
        rx_frame_d      = (rx_pos_q == POS_LAST) ? rx_frame_q + 4'h1 : rx_frame_q;
        sr_d            = {sr_q[5:0], rx_line};
        mf_sr_d         = mf_sr_q;
        mf_lock_d       = mf_lock_q;
        c_rx_d          = c_rx_q;
        rx_cprev_d      = rx_cprev_q;
        cvalid_d        = cvalid_q;
        err_d           = err_q;
        rx_byte_d       = rx_byte_q;
        rx_byte_valid_d = 1'b0;
        rx_sig_d        = rx_sig_q;
        rx_status_d     = rx_status_q;
        rx_status_d.far_crc_err = 1'b0;
        rx_status_d.crc_err     = 1'b0;
        case (st_q)
            RX_HUNT: begin
                if (fas_hit) begin
                    rx_pos_d   = 8'h08;
                    rx_frame_d = 4'h0;
                    st_d       = RX_CHK_NFAS;
                end
            end
            RX_CHK_NFAS: begin
                if (rx_pos_q == 8'h01) begin
                    st_d = rx_line ? RX_CHK_FAS : RX_HUNT;
                end
            end
            RX_CHK_FAS: begin
                if (rx_pos_q == 8'h07 && !rx_frame_q[0]) begin
                    st_d = fas_hit ? RX_SYNC : RX_HUNT;
                end
            end
            RX_SYNC: begin
                if (rx_pos_q == 8'h07 && !rx_frame_q[0] && !fas_hit) begin
                    st_d = RX_HUNT;
                end
            end
            default: st_d = RX_HUNT;
        endcase
        if (st_q == RX_SYNC && st_d == RX_SYNC) begin
            if (rx_pos_q == 8'h00 && rx_frame_q[0]) begin
                mf_sr_d = mf_word;
                if (mf_word == MF_PATTERN) begin
                    rx_frame_d = FRAME_MF_LAST;
                    mf_lock_d  = 1'b1;
                end else if (rx_frame_q == FRAME_MF_LAST) begin
                    mf_lock_d  = 1'b0;
                end
                if (mf_lock_q && rx_frame_q[3:2] == 2'b11) begin
                    rx_status_d.far_crc_err = !rx_line;
                end
            end
            if (rx_pos_q == 8'h00 && !rx_frame_q[0]) begin
                c_rx_d[2'(3 - rx_frame_q[2:1])] = rx_line;
            end
            if (rx_pos_q == 8'({5'h0, BIT_ALARM}) && rx_frame_q[0]) begin
                rx_status_d.far_alarm = rx_line;
            end
            if (rx_smf_start && mf_lock_q) begin
                rx_cprev_d = rx_crc;
                cvalid_d   = 1'b1;
                if (cvalid_q) begin
                    err_d[rx_frame_q[3] ? 0 : 1] = (c_rx_q != rx_cprev_q);
                    rx_status_d.crc_err          = (c_rx_q != rx_cprev_q);
                end
            end
            if (rx_pos_q[2:0] == BIT_LAST) begin
                rx_byte_d       = rbyte;
                rx_byte_valid_d = 1'b1;
                if (rx_pos_q[7:3] == TS_SIGNALLING && mf_lock_q && rx_frame_q != 4'h0) begin
                    rx_sig_d[rx_frame_q]                = rbyte[7:4];
                    rx_sig_d[5'(rx_frame_q) + 5'd15]    = rbyte[3:0];
                end
            end
        end else begin
            mf_lock_d = 1'b0;
            cvalid_d  = 1'b0;
        end
        if (!mf_lock_d) begin
            cvalid_d = 1'b0;
        end
        rx_status_d.frame_aligned = (st_d == RX_SYNC);
        rx_status_d.mf_aligned    = mf_lock_d;
    end

    e1_crc4 u_rx_crc (
        .mclk   (mclk),
        .resetn (resetn),
        .start  (rx_smf_start),
        .din    ((rx_pos_q == 8'h00 && !rx_frame_q[0]) ? 1'b0 : rx_line),
        .crc_q  (rx_crc)
    );

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q            <= RX_HUNT;
            rx_pos_q        <= 8'h00;
            rx_frame_q      <= 4'h0;
            sr_q            <= 7'h00;
            mf_sr_q         <= 6'h00;
            mf_lock_q       <= 1'b0;
            c_rx_q          <= 4'h0;
            rx_cprev_q      <= 4'h0;
            cvalid_q        <= 1'b0;
            err_q           <= 2'h0;
            rx_byte_q       <= 8'h00;
            rx_byte_valid_q <= 1'b0;
            rx_byte_ts_q    <= 5'h00;
            rx_byte_frame_q <= 4'h0;
            rx_sig_q        <= '0;
            rx_status_q     <= '0;
        end else begin
            st_q            <= st_d;
            rx_pos_q        <= rx_pos_d;
            rx_frame_q      <= rx_frame_d;
            sr_q            <= sr_d;
            mf_sr_q         <= mf_sr_d;
            mf_lock_q       <= mf_lock_d;
            c_rx_q          <= c_rx_d;
            rx_cprev_q      <= rx_cprev_d;
            cvalid_q        <= cvalid_d;
            err_q           <= err_d;
            rx_byte_q       <= rx_byte_d;
            rx_byte_valid_q <= rx_byte_valid_d;
            rx_byte_ts_q    <= rx_pos_q[7:3];
            rx_byte_frame_q <= rx_frame_q;
            rx_sig_q        <= rx_sig_d;
            rx_status_q     <= rx_status_d;
        end
    end

    // ---------------- checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    frame_wrap_a: assert property (tx_pos_q == POS_LAST |=> tx_pos_q == 8'h00 &&
        tx_frame_q == 4'($past(tx_frame_q) + 4'h1))
        else $error("frame counter did not advance at end of frame");
    nfas_bits_a: assert property (tx_frame_q[0] && tx_pos_q == 8'h01 |=>
        tx_line_q ##1 tx_line_q == $past(tx_ctrl.rai))
        else $error("non-word frame bit 2 or alarm bit wrong");
    ebit_tx_a: assert property (tx_frame_q == FRAME_E_SMF1 && tx_pos_q == 8'h00 |=>
        tx_line_q == ~$past(err_q[0]))
        else $error("crc error report bit wrong");
    mf_marker_a: assert property (tx_frame_q == 4'h0 && tx_pos_q == 8'h80 |=>
        !tx_line_q [*4])
        else $error("signalling marker not zero");
    align_loss_a: assert property (st_q == RX_SYNC && rx_pos_q == 8'h07 &&
        !rx_frame_q[0] && !fas_hit |=> st_q == RX_HUNT && !rx_status_q.frame_aligned)
        else $error("missed alignment word did not drop sync");
    fas_word_a: assert property (!tx_frame_q[0] && tx_pos_q == 8'h01 |=>
        !tx_line_q ##1 !tx_line_q ##1 tx_line_q ##1 tx_line_q ##1 !tx_line_q
        ##1 tx_line_q ##1 tx_line_q)
        else $error("alignment word pattern wrong");
endmodule // e1_multiframe_framer

// ### bench/e1_far_end.sv
// far-end e1 line terminal model driving the framer receive line
`timescale 1ns/1ps
module e1_far_end
    import e1_framer_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       alarm,
    input  wire logic [1:0] e_bits,
    input  wire logic       corrupt,
    output sig_table_t      sig_tab,
    output logic            line_q
);
    localparam logic [7:0] AW  = 8'h1b;
    localparam logic [5:0] MFP = 6'h0b;
    logic [7:0] pos_q;
    logic [7:0] pos_d;
    logic [3:0] frame_q;
    logic [3:0] frame_d;
    logic [4:0] slot;
    logic [2:0] b;
    logic [3:0] sa;
    logic [3:0] sb;
    logic [7:0] pay;
    logic       bit_d;
    logic [3:0] crc_q;
    logic [3:0] crc_d;
    logic [3:0] cprev_q;
    logic [3:0] cv;
    logic [3:0] base;
    logic       smf_start;
    logic       fb;

    always_comb begin
        for (int n = 1; n <= 30; n++) sig_tab[n] = 4'(n) ^ 4'h9;
    end
    assign slot = pos_q[7:3];
    assign b    = pos_q[2:0];
    assign sa   = sig_tab[frame_q];
    assign sb   = sig_tab[5'(frame_q) + 5'h0f];
    // payload byte names the low three bits of its frame and its slot
    assign pay  = {frame_q[2:0], slot};
    assign smf_start = (pos_q == 8'h00) && (frame_q[2:0] == 3'h0);
    // check bits of a sub-multiframe carry the crc of the one before
    assign cv        = smf_start ? crc_q : cprev_q;

    always_comb begin
        pos_d   = pos_q + 8'h01;
        frame_d = (pos_q == 8'hff) ? frame_q + 4'h1 : frame_q;
        bit_d   = pay[3'h7 - b];
        if (slot == 5'h00 && !frame_q[0]) begin
            bit_d = (b == 3'h0) ? cv[2'(3 - frame_q[2:1])] : AW[3'h7 - b] ^ corrupt;
        end else if (slot == 5'h00) begin
            case (b)
                3'h0: bit_d = (frame_q > 4'hb) ? e_bits[frame_q[1]] : MFP[3'h5 - frame_q[3:1]];
                3'h1: bit_d = 1'b1;
                3'h2: bit_d = alarm;
                default: bit_d = 1'b1;
            endcase
        end else if (slot == 5'h10) begin
            if (frame_q == 4'h0) bit_d = b[2];
            else bit_d = b[2] ? sb[3'h7 - b] : sa[3'h3 - b];
        end
        // crc over the sent bits with check bit positions taken as zero
        base  = smf_start ? 4'h0 : crc_q;
        fb    = ((slot == 5'h00 && !frame_q[0] && b == 3'h0) ? 1'b0 : bit_d) ^ base[3];
        crc_d = {base[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pos_q   <= 8'h00;
            frame_q <= 4'h0;
            line_q  <= 1'b1;
            crc_q   <= 4'h0;
            cprev_q <= 4'h0;
        end else begin
            pos_q   <= pos_d;
            frame_q <= frame_d;
            line_q  <= bit_d;
            crc_q   <= crc_d;
            cprev_q <= cv;
        end
    end
endmodule // e1_far_end

// ### bench/tb.sv
// self-checking bench for the e1 multiframe framer
`timescale 1ns/1ps
module tb
    import e1_framer_pkg::*;
;
    typedef struct packed {
        logic       rai;
        logic [4:0] spare;
        logic [3:0] mfs;
        logic [7:0] data;
        logic       far_al;
        logic [1:0] far_e;
        logic [1:0] npul;
    } row_t;
    localparam logic [7:0] AW  = 8'h1b;
    localparam logic [5:0] MFP = 6'h0b;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic p_rstn = 1'b0;
    logic [7:0] tx_data = 8'h00;
    sig_table_t tx_sig;
    tx_ctrl_t tx_ctrl = '0;
    logic tx_line_q, rx_line, rx_byte_valid_q, far_al = 1'b0, corrupt = 1'b0, chk = 1'b0;
    logic [7:0] tx_pos_q, rx_byte_q, ppos;
    logic [3:0] tx_frame_q, rx_byte_frame_q, pfr;
    logic [4:0] rx_byte_ts_q;
    logic [1:0] far_e = 2'b11;
    logic exp_bit;
    sig_table_t rx_sig_q, p_sig;
    rx_status_t rx_status_q;
    int errors = 0, samples_checked = 0, npulse = 0, ncrc = 0;
    row_t rows [4] = '{'{1'b0, 5'h1f, 4'hf, 8'ha5, 1'b0, 2'b11, 2'd0},
                       '{1'b1, 5'h0a, 4'h5, 8'h3c, 1'b1, 2'b00, 2'd2},
                       '{1'b0, 5'h15, 4'ha, 8'h00, 1'b1, 2'b10, 2'd1},
                       '{1'b1, 5'h00, 4'h0, 8'hff, 1'b0, 2'b01, 2'd1}};

    always #2 mclk = ~mclk;

    e1_multiframe_framer i_e1_multiframe_framer (.mclk(mclk), .resetn(resetn),
        .tx_data(tx_data), .tx_sig(tx_sig), .tx_ctrl(tx_ctrl), .tx_line_q(tx_line_q),
        .tx_pos_q(tx_pos_q), .tx_frame_q(tx_frame_q), .rx_line(rx_line),
        .rx_byte_q(rx_byte_q), .rx_byte_valid_q(rx_byte_valid_q),
        .rx_byte_ts_q(rx_byte_ts_q), .rx_byte_frame_q(rx_byte_frame_q),
        .rx_sig_q(rx_sig_q), .rx_status_q(rx_status_q));
    e1_far_end i_e1_far_end (.mclk(mclk), .resetn(p_rstn), .alarm(far_al), .e_bits(far_e),
        .corrupt(corrupt), .sig_tab(p_sig), .line_q(rx_line));

    task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // waits for frame alignment state; lock also needs multiframe lock
    task automatic wait_aligned(input logic want, input int limit);
        int n;
        n = 0;
        while (!(rx_status_q.frame_aligned === want && (!want || rx_status_q.mf_aligned === 1'b1))
               && n < limit) begin
            @(posedge mclk);
            n++;
        end
        if (n >= limit) begin
            errors++;
            $display("CHECK FAILED frame_aligned expected %0b seen %0b", want,
                     rx_status_q.frame_aligned);
            complete_run();
        end
    endtask

    // expected line bit at position p of frame f; returns 0 where not predictable
    function automatic logic exp_tx(input logic [7:0] p, input logic [3:0] f, output logic e);
        logic [2:0] b;
        logic [4:0] s;
        b = p[2:0];
        s = p[7:3];
        e = tx_data[3'h7 - b];
        exp_tx = 1'b1;
        if (s == 5'h00 && !f[0]) begin
            exp_tx = (b != 3'h0);
            e = AW[3'h7 - b];
        end else if (s == 5'h00) begin
            // clean far-end crc: error bits must report no error
            e = (b == 3'h0) ? ((f > 4'hb) ? 1'b1 : MFP[3'h5 - f[3:1]]) : (b == 3'h1) ? 1'b1 :
                (b == 3'h2) ? tx_ctrl.rai : tx_ctrl.spare[3'h7 - b];
        end else if (s == 5'h10 && f == 4'h0) begin
            e = b[2] ? tx_ctrl.mf_spare[3'h7 - b] : 1'b0;
        end else if (s == 5'h10) begin
            e = b[2] ? tx_sig[5'(f) + 5'h0f][3'h7 - b] : tx_sig[f][3'h3 - b];
        end
    endfunction

    always @(posedge mclk) begin
        ppos <= tx_pos_q;
        pfr  <= tx_frame_q;
        if (chk && exp_tx(ppos, pfr, exp_bit))
            check("tx_line_q", exp_bit, tx_line_q);
        if (chk && rx_byte_valid_q && rx_byte_ts_q != 5'h00 && rx_byte_ts_q != 5'h10)
            check("rx_byte_q", {rx_byte_frame_q[2:0], rx_byte_ts_q}, rx_byte_q);
        if (!chk) npulse <= 0;
        else if (rx_status_q.far_crc_err) npulse <= npulse + 1;
        if (!chk) ncrc <= 0;
        else if (rx_status_q.crc_err) ncrc <= ncrc + 1;
    end

    initial begin
        for (int n = 1; n <= 30; n++) tx_sig[n] = ~4'(n);
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (37) @(posedge mclk);
        p_rstn <= 1'b1;
        wait_aligned(1'b1, 14000);
        foreach (rows[i]) begin
            chk <= 1'b0;
            tx_data <= rows[i].data;
            tx_ctrl <= '{rai: rows[i].rai, spare: rows[i].spare, mf_spare: rows[i].mfs};
            far_al <= rows[i].far_al;
            far_e <= rows[i].far_e;
            repeat (4096) @(posedge mclk);
            chk <= 1'b1;
            repeat (4097) @(posedge mclk);
            check("far_alarm", rows[i].far_al, rx_status_q.far_alarm);
            check("far_crc_err pulses", rows[i].npul, npulse);
            check("crc_err pulses", 8'h00, ncrc);
            check("rx_sig_q", p_sig, rx_sig_q);
            check("aligned", 2'b11, {rx_status_q.frame_aligned, rx_status_q.mf_aligned});
        end
        chk <= 1'b0;
        corrupt <= 1'b1;
        wait_aligned(1'b0, 600);
        corrupt <= 1'b0;
        wait_aligned(1'b1, 14000);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        check("tx_line_q reset", 1'b1, tx_line_q);
        check("tx_pos_q reset", 8'h00, tx_pos_q);
        check("rx_status_q reset", 5'h00, rx_status_q);
        check("rx_sig_q reset", 120'h0, rx_sig_q);
        check("rx_byte_valid_q reset", 1'b0, rx_byte_valid_q);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        check("tx_pos_q after reset", 8'h01, tx_pos_q);
        wait_aligned(1'b1, 14000);
        complete_run();
    end
endmodule // tb
